// [rtl/resp_ctl_pkg.sv]
// Purpose: shared constants and carrier types for the respiration control
// Assumes: AXI4-Lite slave with 32-bit data, one word per register
// Notes: register positions are word indices, byte address is index * 4
package resp_ctl_pkg;

  localparam int AXI_ADDR_WIDTH = 8;
  localparam int REG_WIDTH = 24;

  // word indices and byte addresses
  localparam logic [AXI_ADDR_WIDTH-1:0] RESP_CTL_INDEX = 8'h03;
  localparam logic [AXI_ADDR_WIDTH-1:0] RESP_STATUS_INDEX = 8'h04;
  localparam logic [AXI_ADDR_WIDTH-1:0] RESP_CTL_ADDR = 8'h0C;
  localparam logic [AXI_ADDR_WIDTH-1:0] RESP_STATUS_ADDR = 8'h10;

  // reset value and writable bits of the control word
  localparam logic [REG_WIDTH-1:0] RESP_CTL_RESET = 24'h000001;
  localparam logic [REG_WIDTH-1:0] RESP_CTL_WRITE_MASK = 24'h01FFFF;

  // field positions
  localparam int ENABLE_BIT = 0;
  localparam int CAPACITOR_BIT = 12;
  localparam int DRIVE_PAIR_BIT = 13;
  localparam int AMP_BYPASS_BIT = 14;
  localparam int SYNC_EXPORT_BIT = 15;
  localparam int EVERY_CYCLE_BIT = 16;

  // carrier defaults
  localparam int DAC_WIDTH = 8;
  localparam int GROUP_CYCLES = 8;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef struct packed {
    logic [AXI_ADDR_WIDTH-1:0] addr;
    logic [2:0] prot;
  } axi_addr_type;

  typedef struct packed {
    logic [31:0] data;
    logic [3:0] strb;
  } axi_wdata_type;

  typedef struct packed {
    logic [31:0] data;
    logic [1:0] resp;
  } axi_rdata_type;

  typedef struct packed {
    logic every_cycle;
    logic sync_export;
    logic amp_bypass;
    logic drive_pair;
    logic capacitor;
    logic enable;
  } resp_fields_type;

  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_type;

  typedef struct packed {
    logic left_leg;
    logic left_arm;
    logic right_arm;
    logic amp_bypass;
    logic ext_capacitor;
  } drive_route_type;

endpackage : resp_ctl_pkg

// [rtl/carrier_wave_gen.sv]
// Purpose: respiration carrier ramp feeding the drive dac
// Assumes: one clock, synchronous active-low reset
// Notes: without every-cycle mode one carrier cycle in a group is stretched
`timescale 1ns/1ps
module carrier_wave_gen #(
  parameter int DAC_BITS = resp_ctl_pkg::DAC_WIDTH,
  parameter int GROUP_LEN = resp_ctl_pkg::GROUP_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable,
  input wire logic every_cycle,
  output logic [DAC_BITS-1:0] dac_code,
  output logic cycle_wrap
);
  import resp_ctl_pkg::*;

  localparam int GROUP_BITS = (GROUP_LEN > 1) ? $clog2(GROUP_LEN) : 1;
  localparam logic [GROUP_BITS-1:0] GROUP_LAST = GROUP_BITS'(GROUP_LEN - 1);

  logic [GROUP_BITS-1:0] group_count;
  logic dwell;
  wire at_top = &dac_code;
  wire group_end = (group_count == GROUP_LAST);
  wire need_dwell = at_top && !every_cycle && group_end && !dwell;
  wire step = enable && !need_dwell;
  wire [DAC_BITS-1:0] next_dac_code = dac_code + DAC_BITS'(1);
  wire [GROUP_BITS-1:0] next_group_count =
    group_end ? '0 : group_count + GROUP_BITS'(1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dac_code <= '0;
      group_count <= '0;
      dwell <= 1'b0;
      cycle_wrap <= 1'b0;
    end else begin
      dwell <= enable && need_dwell;
      cycle_wrap <= step && at_top;
      if (step) begin
        dac_code <= next_dac_code;
      end
      if (step && at_top) begin
        group_count <= next_group_count;
      end
    end
  end

endmodule : carrier_wave_gen

// [rtl/drive_router.sv]
// Purpose: routes the drive pair, amplifier bypass, capacitors and pin 3
// Assumes: fields come straight from the control register
// Notes: all outputs are registered
`timescale 1ns/1ps
module drive_router (
  input wire logic aclk,
  input wire logic aresetn,
  input resp_ctl_pkg::resp_fields_type fields,
  input wire logic dac_msb,
  input resp_ctl_pkg::pin_drive_type pin_normal,
  output resp_ctl_pkg::pin_drive_type pin_drive,
  output resp_ctl_pkg::drive_route_type route
);
  import resp_ctl_pkg::*;

  pin_drive_type next_pin_drive;
  drive_route_type next_route;

  assign next_pin_drive = fields.sync_export ?
    pin_drive_type'{out: dac_msb, oe: 1'b1} : pin_normal;
  assign next_route.left_leg = fields.enable && !fields.drive_pair;
  assign next_route.left_arm = fields.enable && fields.drive_pair;
  assign next_route.right_arm = fields.enable || fields.capacitor;
  assign next_route.amp_bypass = fields.amp_bypass;
  assign next_route.ext_capacitor = fields.capacitor;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_drive <= '0;
      route <= '0;
    end else begin
      pin_drive <= next_pin_drive;
      route <= next_route;
    end
  end

endmodule : drive_router

// [rtl/respiration_control_fields.sv]
// Purpose: respiration control register with AXI4-Lite access
// Assumes: aclk at 200 MHz, aresetn synchronous active low
// Notes: control word at index 3, status word at index 4
`timescale 1ns/1ps
module respiration_control_fields #(
  parameter int DAC_BITS = resp_ctl_pkg::DAC_WIDTH,
  parameter int GROUP_LEN = resp_ctl_pkg::GROUP_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input resp_ctl_pkg::axi_addr_type s_axi_aw,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input resp_ctl_pkg::axi_wdata_type s_axi_w,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input resp_ctl_pkg::axi_addr_type s_axi_ar,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output resp_ctl_pkg::axi_rdata_type s_axi_r,
  input wire logic general_pin_three_normal_out,
  input wire logic general_pin_three_normal_oe,
  output logic general_pin_three_out,
  output logic general_pin_three_oe,
  output logic [DAC_BITS-1:0] breathing_drive_dac,
  output logic drive_out_left_leg,
  output logic drive_out_left_arm,
  output logic drive_out_right_arm,
  output logic external_amp_bypass_en,
  output logic capacitor_source_sel
);
  import resp_ctl_pkg::*;

  // register storage
  logic [REG_WIDTH-1:0] respiration_control;

  // write channel holding state
  logic aw_held;
  logic w_held;
  logic [AXI_ADDR_WIDTH-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // carrier state
  logic [DAC_BITS-1:0] dac_code;
  logic cycle_wrap;
  logic [15:0] wrap_count;

  // exported msb period watch
  localparam int PERIOD_BITS = DAC_BITS + 2;
  logic msb_seen;
  logic [1:0] rises_seen;
  logic [PERIOD_BITS-1:0] period_count;
  logic [PERIOD_BITS-1:0] last_period;
  logic period_varied;

  // byte-lane merge used only by the control register write
  function automatic logic [REG_WIDTH-1:0] merge_lanes(
    input logic [REG_WIDTH-1:0] old_value,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [REG_WIDTH-1:0] result;
    result = old_value;
    for (int lane = 0; lane < REG_WIDTH / 8; lane++) begin
      if (strb[lane]) begin
        result[lane*8 +: 8] = data[lane*8 +: 8];
      end
    end
    return result;
  endfunction : merge_lanes

  // word address match, ignoring the low two byte bits
  function automatic logic addr_is(
    input logic [AXI_ADDR_WIDTH-1:0] addr,
    input logic [AXI_ADDR_WIDTH-1:0] target
  );
    return addr[AXI_ADDR_WIDTH-1:2] == target[AXI_ADDR_WIDTH-1:2];
  endfunction : addr_is

  // field view of the control word
  resp_fields_type fields;
  assign fields.every_cycle = respiration_control[EVERY_CYCLE_BIT];
  assign fields.sync_export = respiration_control[SYNC_EXPORT_BIT];
  assign fields.amp_bypass = respiration_control[AMP_BYPASS_BIT];
  assign fields.drive_pair = respiration_control[DRIVE_PAIR_BIT];
  assign fields.capacitor = respiration_control[CAPACITOR_BIT];
  assign fields.enable = respiration_control[ENABLE_BIT];

  // write address and data are accepted in either order
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_held || aw_take;
  wire w_have = w_held || w_take;
  wire write_fire = aw_have && w_have && !s_axi_bvalid;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;

  wire [AXI_ADDR_WIDTH-1:0] wr_addr = aw_held ? aw_addr : s_axi_aw.addr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_w.data;
  wire [3:0] wr_strb = w_held ? w_strb : s_axi_w.strb;

  wire wr_hits_ctl = addr_is(wr_addr, RESP_CTL_ADDR);
  wire wr_hits_status = addr_is(wr_addr, RESP_STATUS_ADDR);
  wire wr_mapped = wr_hits_ctl || wr_hits_status;

  wire [REG_WIDTH-1:0] next_respiration_control =
    merge_lanes(respiration_control, wr_data, wr_strb) & RESP_CTL_WRITE_MASK;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (write_fire) begin
      aw_held <= 1'b0;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_aw.addr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (write_fire) begin
      w_held <= 1'b0;
    end else if (w_take) begin
      w_held <= 1'b1;
      w_data <= s_axi_w.data;
      w_strb <= s_axi_w.strb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      respiration_control <= RESP_CTL_RESET;
    end else if (write_fire && wr_hits_ctl) begin
      respiration_control <= next_respiration_control;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (write_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_DECERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read path: one read in flight, answer one cycle after the address
  wire ar_take = s_axi_arvalid && s_axi_arready;
  assign s_axi_arready = !s_axi_rvalid;

  wire rd_hits_ctl = addr_is(s_axi_ar.addr, RESP_CTL_ADDR);
  wire rd_hits_status = addr_is(s_axi_ar.addr, RESP_STATUS_ADDR);

  // status word: dac code, pin three state, period flag, wrap count
  wire [31:0] status_word = {wrap_count[7:0], 5'h00, period_varied,
    general_pin_three_oe, general_pin_three_out,
    {(16 - DAC_BITS){1'b0}}, dac_code};

  wire [31:0] ctl_word = {8'h00, respiration_control & RESP_CTL_WRITE_MASK};

  axi_rdata_type next_read;
  assign next_read.data = rd_hits_ctl ? ctl_word :
    (rd_hits_status ? status_word : 32'h00000000);
  assign next_read.resp = (rd_hits_ctl || rd_hits_status) ?
    RESP_OKAY : RESP_DECERR;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_r <= '0;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_r <= next_read;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // carrier cycles completed, shown in the status word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wrap_count <= '0;
    end else if (cycle_wrap) begin
      wrap_count <= wrap_count + 16'h0001;
    end
  end

  // msb period watch
  // rise-to-rise length of the dac msb, compared with the one before;
  // the flag stays set until software writes the status word, so a
  // stretched carrier cycle is caught even between reads
  wire msb_now = dac_code[DAC_BITS-1];
  wire msb_rise = msb_now && !msb_seen;
  wire period_full = &period_count;
  wire period_valid = (rises_seen == 2'h2);
  wire [1:0] next_rises_seen =
    period_valid ? rises_seen : rises_seen + 2'h1;
  wire [PERIOD_BITS-1:0] next_period_count =
    msb_rise ? PERIOD_BITS'(1) :
    (period_full ? period_count : period_count + PERIOD_BITS'(1));
  wire period_differs =
    msb_rise && period_valid && (period_count != last_period);
  wire varied_clear = write_fire && wr_hits_status;

  // reset level matches the dac reset code, so no false rise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      msb_seen <= 1'b0;
    end else begin
      msb_seen <= msb_now;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_count <= '0;
    end else begin
      period_count <= next_period_count;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rises_seen <= 2'h0;
      last_period <= '0;
    end else if (msb_rise) begin
      rises_seen <= next_rises_seen;
      last_period <= period_count;
    end
  end

  // a new change wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_varied <= 1'b0;
    end else if (period_differs) begin
      period_varied <= 1'b1;
    end else if (varied_clear) begin
      period_varied <= 1'b0;
    end
  end

  carrier_wave_gen #(
    .DAC_BITS(DAC_BITS),
    .GROUP_LEN(GROUP_LEN)
  ) carrier (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(fields.enable),
    .every_cycle(fields.every_cycle),
    .dac_code(dac_code),
    .cycle_wrap(cycle_wrap)
  );

  assign breathing_drive_dac = dac_code;

  pin_drive_type pin_normal;
  pin_drive_type pin_drive;
  drive_route_type route;

  assign pin_normal.out = general_pin_three_normal_out;
  assign pin_normal.oe = general_pin_three_normal_oe;

  // pin three export and drive pair routing
  drive_router router (
    .aclk(aclk),
    .aresetn(aresetn),
    .fields(fields),
    .dac_msb(dac_code[DAC_BITS-1]),
    .pin_normal(pin_normal),
    .pin_drive(pin_drive),
    .route(route)
  );

  assign general_pin_three_out = pin_drive.out;
  assign general_pin_three_oe = pin_drive.oe;
  assign drive_out_left_leg = route.left_leg;
  assign drive_out_left_arm = route.left_arm;
  assign drive_out_right_arm = route.right_arm;
  assign external_amp_bypass_en = route.amp_bypass;
  assign capacitor_source_sel = route.ext_capacitor;

endmodule : respiration_control_fields

// [sim/resp_ctl_checker_assertions.sv]
// Purpose: port-level checks for the respiration control block
// Assumes: one clock, synchronous active-low reset
// Notes: bound into every instance of the top module
`timescale 1ns/1ps
module resp_ctl_checker #(
  parameter int DAC_BITS = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input resp_ctl_pkg::axi_addr_type s_axi_ar,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input resp_ctl_pkg::axi_rdata_type s_axi_r,
  input wire logic general_pin_three_normal_oe,
  input wire logic general_pin_three_out,
  input wire logic general_pin_three_oe,
  input wire logic [DAC_BITS-1:0] breathing_drive_dac,
  input wire logic drive_out_left_leg,
  input wire logic drive_out_left_arm,
  input wire logic drive_out_right_arm
);
  import resp_ctl_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire [DAC_BITS-1:0] dac = breathing_drive_dac;

  AST_PAIR_EXCL: assert property (
    !(drive_out_left_leg && drive_out_left_arm)) else $error("two pairs on");
  AST_RA_WITH_PAIR: assert property (
    drive_out_left_leg || drive_out_left_arm |-> drive_out_right_arm)
    else $error("right arm missing");
  AST_PIN_MSB: assert property (
    general_pin_three_oe && !$past(general_pin_three_normal_oe)
    |-> general_pin_three_out == $past(dac[DAC_BITS-1]))
    else $error("pin three not dac msb");
  AST_DAC_STEP: assert property (
    $changed(dac) |-> dac == DAC_BITS'($past(dac) + 1'b1))
    else $error("dac step wrong");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_r)) else $error("r dropped");
  AST_B_BLOCK: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("write not held off");
  AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read not held off");
  AST_CTL_READ: assert property (
    ar_take && s_axi_ar.addr == RESP_CTL_ADDR |=> s_axi_rvalid
    && s_axi_r.data[31:17] == '0 && s_axi_r.resp == RESP_OKAY)
    else $error("control read upper bits");
  AST_DECERR_READ: assert property (ar_take && s_axi_ar.addr[7:2] > 6'h04
    |=> s_axi_rvalid && s_axi_r.data == '0 && s_axi_r.resp == RESP_DECERR)
    else $error("unmapped read answer");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (general_pin_three_oe && general_pin_three_out);
  cover property (s_axi_rvalid && s_axi_r.resp == RESP_DECERR);
endmodule : resp_ctl_checker

bind respiration_control_fields resp_ctl_checker #(.DAC_BITS(DAC_BITS))
  chk_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_ar(s_axi_ar), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_r(s_axi_r),
  .general_pin_three_normal_oe(general_pin_three_normal_oe),
  .general_pin_three_out(general_pin_three_out),
  .general_pin_three_oe(general_pin_three_oe),
  .breathing_drive_dac(breathing_drive_dac),
  .drive_out_left_leg(drive_out_left_leg),
  .drive_out_left_arm(drive_out_left_arm),
  .drive_out_right_arm(drive_out_right_arm));

// [sim/respiration_control_fields_tb.sv]
// Purpose: directed bench for the respiration control block
// Assumes: 200 MHz clock, dac narrowed to 4 bits for short periods
// Notes: bready and rready are raised together with each request
`timescale 1ns/1ps
module respiration_control_fields_tb;
  import resp_ctl_pkg::*;
  localparam int DB = 4;
  logic aclk = 0, aresetn = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic general_pin_three_normal_out = 0, general_pin_three_normal_oe = 0;
  axi_addr_type s_axi_aw = '0, s_axi_ar = '0;
  axi_wdata_type s_axi_w = '0;
  axi_rdata_type s_axi_r, rd;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, general_pin_three_out, general_pin_three_oe;
  logic [1:0] s_axi_bresp, br;
  logic [DB-1:0] breathing_drive_dac;
  logic drive_out_left_leg, drive_out_left_arm, drive_out_right_arm;
  logic external_amp_bypass_en, capacitor_source_sel;
  int num_errors = 0, compares = 0, p, q;

  always #2.5 aclk = ~aclk;

  respiration_control_fields #(.DAC_BITS(DB)) dut_u (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_aw(s_axi_aw),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_w(s_axi_w), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_ar(s_axi_ar), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .s_axi_r(s_axi_r),
    .general_pin_three_normal_out(general_pin_three_normal_out),
    .general_pin_three_normal_oe(general_pin_three_normal_oe),
    .general_pin_three_out(general_pin_three_out),
    .general_pin_three_oe(general_pin_three_oe),
    .breathing_drive_dac(breathing_drive_dac),
    .drive_out_left_leg(drive_out_left_leg),
    .drive_out_left_arm(drive_out_left_arm),
    .drive_out_right_arm(drive_out_right_arm),
    .external_amp_bypass_en(external_amp_bypass_en),
    .capacitor_source_sel(capacitor_source_sel));

  function automatic logic [31:0] routes();
    return {27'h0, drive_out_left_leg, drive_out_left_arm,
      drive_out_right_arm, external_amp_bypass_en, capacitor_source_sel};
  endfunction : routes

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    if (num_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_aw <= '{a, 3'h0};
    s_axi_w <= '{d, 4'hF};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    br = s_axi_bresp;
    s_axi_bready <= 0;
    @(posedge aclk);
  endtask : wr

  task automatic rdw(input logic [7:0] a);
    s_axi_ar <= '{a, 3'h0};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    rd = s_axi_r;
    s_axi_rready <= 0;
    @(posedge aclk);
  endtask : rdw

  // cycles from one rise of pin three to the next
  task automatic gap(output int c);
    c = 1;
    @(posedge aclk);
    while (general_pin_three_out) begin
      @(posedge aclk);
      c++;
    end
    while (!general_pin_three_out) begin
      @(posedge aclk);
      c++;
    end
  endtask : gap

  task automatic t_reset();
    rdw(RESP_CTL_ADDR);
    chk(rd.data, {8'h0, RESP_CTL_RESET});
    chk(routes(), 32'h14);
    chk(32'(general_pin_three_oe), 32'h0);
  endtask : t_reset

  task automatic t_fields();
    logic [31:0] v [6] = '{32'h2001, 32'h1001, 32'h4001, 32'h3001,
      32'h1000, 32'h0000};
    logic [31:0] e [6] = '{32'h0C, 32'h15, 32'h16, 32'h0D, 32'h05, 32'h00};
    for (int i = 0; i < 6; i++) begin
      wr(RESP_CTL_ADDR, v[i]);
      chk(routes(), e[i]);
    end
  endtask : t_fields

  task automatic t_reserved();
    wr(RESP_CTL_ADDR, 32'h0001FFFF);
    rdw(RESP_CTL_ADDR);
    chk(rd.data, 32'h01FFFF);
    chk(32'(general_pin_three_oe), 32'h1);
  endtask : t_reserved

  task automatic t_sync();
    gap(p);
    gap(p);
    gap(q);
    chk(p, 1 << DB);
    chk(q, 1 << DB);
    wr(RESP_STATUS_ADDR, 32'h0);
    chk(br, RESP_OKAY);
    repeat (3) gap(p);
    rdw(RESP_STATUS_ADDR);
    chk(32'(rd.data[18]), 32'h0);
    wr(RESP_CTL_ADDR, 32'h8001);
    gap(p);
    q = 0;
    repeat (GROUP_CYCLES) begin
      gap(p);
      q += p;
    end
    chk(q, GROUP_CYCLES * (1 << DB) + 1);
    rdw(RESP_STATUS_ADDR);
    chk(32'(rd.data[18]), 32'h1);
    general_pin_three_normal_out <= 1;
    general_pin_three_normal_oe <= 1;
    wr(RESP_CTL_ADDR, 32'h0001);
    chk({general_pin_three_oe, general_pin_three_out}, 32'h3);
    general_pin_three_normal_out <= 0;
    repeat (2) @(posedge aclk);
    chk(32'(general_pin_three_out), 32'h0);
  endtask : t_sync

  task automatic t_unmapped();
    rdw(8'h20);
    chk(rd.data, 32'h0);
    chk(rd.resp, RESP_DECERR);
    wr(8'h20, 32'hFFFF);
    chk(br, RESP_DECERR);
    rdw(RESP_CTL_ADDR);
    chk(rd.data, 32'h0001);
    rdw(RESP_STATUS_ADDR);
    chk(rd.data[17:16], 2'h2);
    chk(rd.resp, RESP_OKAY);
  endtask : t_unmapped

  initial begin
    #100000;
    num_errors++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_reset();
    t_fields();
    t_reserved();
    t_sync();
    t_unmapped();
    wrap_up();
  end
endmodule : respiration_control_fields_tb
